// ### design/dct_pkg.sv
// ==========================================================================
// Shared constants, types and the test-output mapping.
package dct_pkg;

    // ======================================================================
    // Clock and timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLOCK_INPUT_VALID_TIME_NS = 200;
    localparam int INPUT_ENABLE_TIME_NS = 120;
    localparam int OUTPUT_VALID_TIME_NS = 80;
    localparam int RESET_HOLD_TIME_NS = 400;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CLOCK_INPUT_VALID_CYC =
        CNT_W'((CLOCK_INPUT_VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] INPUT_ENABLE_CYC =
        CNT_W'((INPUT_ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OUTPUT_VALID_CYC =
        CNT_W'((OUTPUT_VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RESET_HOLD_CYC =
        CNT_W'((RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PIN_SYNC_CYC = 8'h02;

    // ======================================================================
    // Widths and output masks.
    localparam int DQ_W = 16;
    localparam int DQS_W = 4;
    localparam int OUT_W = DQ_W + DQS_W;
    localparam logic [OUT_W-1:0] MASK_X4 = 20'h3000F;
    localparam logic [OUT_W-1:0] MASK_X8 = 20'h300FF;
    localparam logic [OUT_W-1:0] MASK_X16 = 20'hFFFFF;

    typedef enum logic [1:0] {
        WIDTH_X4 = 2'h0,
        WIDTH_X8 = 2'h1,
        WIDTH_X16 = 2'h2
    } dct_width_e;

    // Test input pins; addr[14] is WE_n, addr[15] CAS_n, addr[16] RAS_n.
    typedef struct packed {
        logic [16:0] addr;
        logic [1:0] ba;
        logic [1:0] bg;
        logic actN;
        logic odt;
        logic cke;
        logic par;
        logic alertN;
        logic ckT;
        logic ckC;
        logic dmL;
        logic dmU;
    } dct_pattern_s;

    // ======================================================================
    // Test outputs as {UDQS_c, UDQS_t, LDQS_c, LDQS_t, DQ[15:0]}.
    function automatic logic [OUT_W-1:0] dct_ct_outputs(input dct_pattern_s p, input logic tenGate,
                                                        input dct_width_e w);
        logic [9:0] mt;
        logic [DQ_W-1:0] dq;
        logic [DQS_W-1:0] dqs;
        mt[0] = p.addr[1] ^ p.addr[6] ^ p.par;
        mt[1] = p.addr[8] ^ p.alertN ^ p.addr[9];
        mt[2] = p.addr[2] ^ p.addr[5] ^ p.addr[13];
        mt[3] = p.addr[0] ^ p.addr[7] ^ p.addr[11];
        mt[4] = p.ckC ^ p.odt ^ p.addr[15];
        mt[5] = p.cke ^ p.addr[16] ^ p.addr[10];
        mt[6] = p.actN ^ p.addr[4] ^ p.ba[1];
        mt[8] = p.addr[14] ^ p.addr[12] ^ p.ba[0];
        mt[9] = p.bg[0] ^ p.addr[3] ^ tenGate;
        case (w)
            WIDTH_X16: begin
                mt[7] = p.dmU ^ p.dmL ^ p.ckT;
                dq = {~mt[7:0], mt[7:0]};
                dqs = {~mt[9], ~mt[8], mt[9], mt[8]};
            end
            WIDTH_X8: begin
                mt[7] = p.bg[1] ^ p.dmL ^ p.ckT;
                dq = {8'h00, mt[7:0]};
                dqs = {2'h0, mt[9], mt[8]};
            end
            default: begin
                mt[7] = p.bg[1] ^ p.ckT;
                dq = {12'h000, mt[6] ^ mt[7], mt[4] ^ mt[5], mt[2] ^ mt[3], mt[0] ^ mt[1]};
                dqs = {2'h0, mt[9], mt[8]};
            end
        endcase
        return {dqs, dq};
    endfunction : dct_ct_outputs

    function automatic logic [OUT_W-1:0] dct_out_mask(input dct_width_e w);
        case (w)
            WIDTH_X16: return MASK_X16;
            WIDTH_X8: return MASK_X8;
            default: return MASK_X4;
        endcase
    endfunction : dct_out_mask

endpackage : dct_pkg

// ### design/dct_link_if.sv
`timescale 1ns/1ns
// ==========================================================================
// Board pins between the memory device and the tester.
interface dct_link_if;
    logic ten;
    logic csN;
    logic resetN;
    dct_pkg::dct_pattern_s pat;
    logic [dct_pkg::DQ_W-1:0] dqOut;
    logic [dct_pkg::DQS_W-1:0] dqsOut;
    logic outOeN;
    logic [dct_pkg::DQ_W-1:0] dqPin;
    logic [dct_pkg::DQS_W-1:0] dqsPin;

    // ======================================================================
    // Pin levels resolved from the device's output enable.
    assign dqPin = outOeN ? '0 : dqOut;
    assign dqsPin = outOeN ? '0 : dqsOut;

    modport device (input ten, input csN, input resetN, input pat,
                    output dqOut, output dqsOut, output outOeN);
    modport tester (output ten, output csN, output resetN, output pat,
                    input dqPin, input dqsPin);
endinterface : dct_link_if

// ### design/dct_device_end.sv
`timescale 1ns/1ns
// Behaviour
// - TEN high enters test mode, low leaves.
// - Tester holds TEN low in normal operation.
// - Test mode bypasses normal memory function.
// - Test mode forces data reference to half.
// - Outputs driven only while CS_n low.
// - Tester keeps RESET_n high during test mode.
// - Minterms zero to three from address pins.
// - Minterms four to six from command pins.
// - Minterm seven depends on device width.
// - Minterm nine includes RESET_n and TEN.
// - x4 DQ outputs pair minterms through XOR; strobes copy minterms eight and nine.
// - x8 outputs copy minterms directly.
// - x16 upper half inverts lower half.
// - Tester enters only after power-up, reset high.
// - Clock inputs first, others after enable time.
// - Outputs settle within valid time, unclocked.
// - No refresh while test mode active.
// - Tester stops using test mode after calibration.
// - Exit anytime; contents undefined, reset required.
module dct_device_end #(
    parameter dct_pkg::dct_width_e WIDTH = dct_pkg::WIDTH_X16
) (
    input wire logic clk,
    input wire logic sys_rst,
    dct_link_if.device link,
    input wire logic refreshReq,
    output logic refreshGrant,
    output logic testModeActive,
    output logic vrefHalfForced,
    output logic normalBypass,
    output logic arrayUndefined,
    output logic resetFault
);

    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_CLKIN = 2'h1,
        ST_ENABLING = 2'h3,
        ST_ACTIVE = 2'h2
    } dct_dev_state_e;

    logic [2:0] pinMeta_reg;
    logic [2:0] pinSync_reg;
    logic tenSync;
    logic csNSync;
    logic resetNSync;
    dct_dev_state_e state_reg;
    logic [dct_pkg::CNT_W-1:0] count_reg;
    logic resetSeenHigh_reg;
    logic inMode;
    logic exitNow;
    logic [dct_pkg::OUT_W-1:0] testOut;
    logic isActive;
    logic outDrive;
    logic tenGate;

    // ======================================================================
    // Two-stage synchronisers for TEN, CS_n and RESET_n.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinMeta_reg <= 3'h0;
        end else begin
            pinMeta_reg <= {link.resetN, link.csN, link.ten};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinSync_reg <= 3'h0;
        end else begin
            pinSync_reg <= pinMeta_reg;
        end
    end

    assign tenSync = pinSync_reg[0];
    assign csNSync = pinSync_reg[1];
    assign resetNSync = pinSync_reg[2];
    assign inMode = (state_reg != ST_OFF);
    assign exitNow = inMode && !tenSync;
    assign isActive = (state_reg == ST_ACTIVE);

    // ======================================================================
    // RESET_n must have been seen high before entry is honoured.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resetSeenHigh_reg <= 1'b0;
        end else if (!resetNSync) begin
            resetSeenHigh_reg <= 1'b0;
        end else begin
            resetSeenHigh_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Entry sequence: clock inputs first, then the remaining inputs.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_OFF;
            count_reg <= '0;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    if (tenSync && resetSeenHigh_reg) begin
                        state_reg <= ST_CLKIN;
                        count_reg <= dct_pkg::CLOCK_INPUT_VALID_CYC - 8'h01;
                    end
                end
                ST_CLKIN: begin
                    if (!tenSync) begin
                        state_reg <= ST_OFF;
                    end else if (count_reg == '0) begin
                        state_reg <= ST_ENABLING;
                        count_reg <= dct_pkg::INPUT_ENABLE_CYC - 8'h01;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                ST_ENABLING: begin
                    if (!tenSync) begin
                        state_reg <= ST_OFF;
                    end else if (count_reg != '0) begin
                        count_reg <= count_reg - 8'h01;
                    end else if (!csNSync) begin
                        state_reg <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (!tenSync) begin
                        state_reg <= ST_OFF;
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // ======================================================================
    // Test path from input pins to output pins.
    assign tenGate = link.resetN & link.ten;
    assign testOut = dct_pkg::dct_ct_outputs(link.pat, tenGate, WIDTH);

    assign link.dqOut = isActive ? testOut[dct_pkg::DQ_W-1:0] : 16'h0000;
    assign link.dqsOut = isActive ? testOut[dct_pkg::OUT_W-1:dct_pkg::DQ_W] : 4'h0;

    // ======================================================================
    // Output enable follows the raw pins so that release is immediate.
    assign outDrive = link.ten && isActive && !link.csN;
    assign link.outOeN = !outDrive;

    // ======================================================================
    // Status seen by the rest of the memory.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            testModeActive <= 1'b0;
        end else begin
            testModeActive <= (state_reg == ST_ACTIVE);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vrefHalfForced <= 1'b0;
        end else begin
            vrefHalfForced <= inMode;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            normalBypass <= 1'b0;
        end else begin
            normalBypass <= inMode || tenSync;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            refreshGrant <= 1'b0;
        end else begin
            refreshGrant <= refreshReq && !inMode && !tenSync;
        end
    end

    // ======================================================================
    // Sticky flags; a setting event wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arrayUndefined <= 1'b0;
        end else if (exitNow) begin
            arrayUndefined <= 1'b1;
        end else if (!resetNSync) begin
            arrayUndefined <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resetFault <= 1'b0;
        end else if (inMode && tenSync && !resetNSync) begin
            resetFault <= 1'b1;
        end else if (state_reg == ST_OFF && tenSync) begin
            resetFault <= 1'b0;
        end
    end

endmodule : dct_device_end

// ### design/dct_tester_end.sv
`timescale 1ns/1ns
// ==========================================================================
// Board tester: enters test mode, applies patterns, checks results.
module dct_tester_end #(
    parameter dct_pkg::dct_width_e WIDTH = dct_pkg::WIDTH_X16
) (
    input wire logic clk,
    input wire logic sys_rst,
    dct_link_if.tester link,
    input wire logic powerGood,
    input wire logic calibrated,
    input wire logic startReq,
    input wire logic exitReq,
    input wire dct_pkg::dct_pattern_s pattern,
    output logic busy,
    output logic done,
    output logic refused,
    output logic mismatch,
    output logic [dct_pkg::DQ_W-1:0] resultDq,
    output logic [dct_pkg::DQS_W-1:0] resultDqs
);

    typedef enum logic [2:0] {
        TS_IDLE = 3'h0,
        TS_ENTER_CLK = 3'h1,
        TS_ENTER_EN = 3'h3,
        TS_APPLY = 3'h2,
        TS_SAMPLE = 3'h6,
        TS_READY = 3'h7,
        TS_EXIT = 3'h5
    } dct_tst_state_e;

    dct_tst_state_e state_reg;
    logic [dct_pkg::CNT_W-1:0] count_reg;
    dct_pkg::dct_pattern_s held_reg;
    logic [dct_pkg::OUT_W-1:0] pinMeta_reg;
    logic [dct_pkg::OUT_W-1:0] pinSync_reg;
    logic [dct_pkg::OUT_W-1:0] expected;

    // ======================================================================
    // Two-stage synchroniser on the device's test outputs.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
        end else begin
            pinMeta_reg <= {link.dqsPin, link.dqPin};
            pinSync_reg <= pinMeta_reg;
        end
    end

    assign expected = dct_pkg::dct_ct_outputs(link.pat, link.ten & link.resetN, WIDTH);

    // ======================================================================
    // Sequencer driving the pins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= TS_IDLE;
            count_reg <= '0;
            link.ten <= 1'b0;
            link.csN <= 1'b1;
            link.resetN <= 1'b1;
            link.pat <= '0;
            held_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            refused <= 1'b0;
            mismatch <= 1'b0;
            resultDq <= '0;
            resultDqs <= '0;
        end else begin
            done <= 1'b0;
            refused <= 1'b0;
            case (state_reg)
                TS_IDLE: begin
                    link.ten <= 1'b0;
                    link.resetN <= 1'b1;
                    if (startReq && (calibrated || !powerGood)) begin
                        refused <= 1'b1;
                    end else if (startReq) begin
                        state_reg <= TS_ENTER_CLK;
                        busy <= 1'b1;
                        held_reg <= pattern;
                        link.ten <= 1'b1;
                        link.csN <= 1'b1;
                        link.pat <= '0;
                        link.pat.cke <= 1'b1;
                        count_reg <= dct_pkg::CLOCK_INPUT_VALID_CYC - 8'h01;
                    end
                end
                TS_ENTER_CLK: begin
                    if (count_reg == '0) begin
                        state_reg <= TS_ENTER_EN;
                        count_reg <= dct_pkg::INPUT_ENABLE_CYC + dct_pkg::PIN_SYNC_CYC;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                TS_ENTER_EN: begin
                    if (count_reg == '0) begin
                        state_reg <= TS_APPLY;
                        link.csN <= 1'b0;
                        link.pat <= held_reg;
                        count_reg <= dct_pkg::OUTPUT_VALID_CYC + dct_pkg::PIN_SYNC_CYC;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                TS_APPLY: begin
                    if (count_reg == '0) begin
                        state_reg <= TS_SAMPLE;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                TS_SAMPLE: begin
                    state_reg <= TS_READY;
                    busy <= 1'b0;
                    done <= 1'b1;
                    resultDq <= pinSync_reg[dct_pkg::DQ_W-1:0];
                    resultDqs <= pinSync_reg[dct_pkg::OUT_W-1:dct_pkg::DQ_W];
                    mismatch <= |((pinSync_reg ^ expected) & dct_pkg::dct_out_mask(WIDTH));
                end
                TS_READY: begin
                    if (exitReq) begin
                        state_reg <= TS_EXIT;
                        busy <= 1'b1;
                        link.ten <= 1'b0;
                        link.csN <= 1'b1;
                        link.resetN <= 1'b0;
                        count_reg <= dct_pkg::RESET_HOLD_CYC - 8'h01;
                    end else if (startReq) begin
                        state_reg <= TS_APPLY;
                        busy <= 1'b1;
                        link.pat <= pattern;
                        count_reg <= dct_pkg::OUTPUT_VALID_CYC + dct_pkg::PIN_SYNC_CYC;
                    end
                end
                TS_EXIT: begin
                    if (count_reg == '0) begin
                        state_reg <= TS_IDLE;
                        busy <= 1'b0;
                        link.resetN <= 1'b1;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= TS_IDLE;
                end
            endcase
        end
    end

endmodule : dct_tester_end

// ### test/dct_link_checker.sv
`timescale 1ns/1ns
// ==========================================================================
// Pin relations between the device end and the tester end.
module dct_link_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ten,
    input wire logic csN,
    input wire logic resetN,
    input wire dct_pkg::dct_pattern_s pat,
    input wire logic [dct_pkg::DQ_W-1:0] dqOut,
    input wire logic [dct_pkg::DQS_W-1:0] dqsOut,
    input wire logic outOeN
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_cs_off;
        csN |-> outOeN;
    endproperty
    a_cs_off: assert property (p_cs_off) else $error("Outputs enabled while chip select high.");
    property p_ten_off;
        !ten |-> outOeN;
    endproperty
    a_ten_off: assert property (p_ten_off) else $error("Outputs enabled outside test mode.");
    property p_entry;
        $rose(ten) |-> outOeN [*8];
    endproperty
    a_entry: assert property (p_entry) else $error("Outputs enabled too soon after entry.");
    property p_hold_rst;
        ten |-> resetN;
    endproperty
    a_hold_rst: assert property (p_hold_rst) else $error("Reset pin low in test mode.");
    property p_rst_pulse;
        $fell(resetN) |-> !resetN [*8];
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("Reset pulse after exit too short.");
    property p_mt0;
        !outOeN |-> dqOut[0] == (pat.addr[1] ^ pat.addr[6] ^ pat.par);
    endproperty
    a_mt0: assert property (p_mt0) else $error("DQ0 does not follow minterm zero.");
    property p_mt4;
        !outOeN |-> dqOut[4] == (pat.ckC ^ pat.odt ^ pat.addr[15]);
    endproperty
    a_mt4: assert property (p_mt4) else $error("DQ4 does not follow its minterm.");
    property p_mt7;
        !outOeN |-> dqOut[7] == (pat.dmU ^ pat.dmL ^ pat.ckT);
    endproperty
    a_mt7: assert property (p_mt7) else $error("DQ7 does not follow minterm seven.");
    property p_mt9;
        !outOeN |-> dqsOut[1] == (pat.bg[0] ^ pat.addr[3] ^ (resetN & ten));
    endproperty
    a_mt9: assert property (p_mt9) else $error("Lower strobe c does not follow minterm nine.");
    property p_upper;
        !outOeN |-> dqOut[15:8] == ~dqOut[7:0] && dqsOut[3:2] == ~dqsOut[1:0];
    endproperty
    a_upper: assert property (p_upper) else $error("Upper half is not the inverse of lower half.");
    property p_settle;
        !outOeN && $past(!outOeN) && $stable(pat) |-> $stable(dqOut);
    endproperty
    a_settle: assert property (p_settle) else $error("Outputs moved with steady inputs.");
    c_drive: cover property (!outOeN);
    c_enter: cover property ($rose(ten) ##[1:30] !outOeN);
    c_exit: cover property ($fell(ten));
endmodule : dct_link_checker

// ### test/tb.sv
`timescale 1ns/1ns
// ==========================================================================
// Both ends joined, plus one directly driven device for each width.
module tb;
    localparam logic [19:0] MASKS [3] = '{dct_pkg::MASK_X4, dct_pkg::MASK_X8, dct_pkg::MASK_X16};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic powerGood = 1'b0;
    logic calibrated = 1'b0;
    logic startReq = 1'b0;
    logic exitReq = 1'b0;
    logic refreshReq = 1'b0;
    dct_pkg::dct_pattern_s pattern = '0;
    logic dTen = 1'b0;
    logic dCsN = 1'b1;
    logic dResetN = 1'b0;
    dct_pkg::dct_pattern_s dPat = '0;
    logic busy, done, refused, mismatch, refreshGrant, testModeActive, vrefHalfForced, normalBypass;
    logic arrayUndefined, resetFault;
    logic [dct_pkg::DQ_W-1:0] resultDq;
    logic [dct_pkg::DQS_W-1:0] resultDqs;
    wire [19:0] dOut [3];
    wire [2:0] dFault;
    wire [2:0] dUndef;
    wire [2:0] dOeN;
    int errTotal = 0;
    int samplesChecked = 0;
    int cycles = 0;

    // ======================================================================
    // Joined ends.
    dct_link_if link ();
    dct_device_end dct_device_end_inst (.clk(clk), .sys_rst(sys_rst), .link(link.device),
        .refreshReq(refreshReq), .refreshGrant(refreshGrant), .testModeActive(testModeActive),
        .vrefHalfForced(vrefHalfForced), .normalBypass(normalBypass), .arrayUndefined(arrayUndefined),
        .resetFault(resetFault));
    dct_tester_end dct_tester_end_inst (.clk(clk), .sys_rst(sys_rst), .link(link.tester),
        .powerGood(powerGood), .calibrated(calibrated), .startReq(startReq), .exitReq(exitReq),
        .pattern(pattern), .busy(busy), .done(done), .refused(refused), .mismatch(mismatch),
        .resultDq(resultDq), .resultDqs(resultDqs));
    dct_link_checker dct_link_checker_inst (.clk(clk), .sys_rst(sys_rst), .ten(link.ten), .csN(link.csN),
        .resetN(link.resetN), .pat(link.pat), .dqOut(link.dqOut), .dqsOut(link.dqsOut), .outOeN(link.outOeN));

    // ======================================================================
    // Directly driven devices, index is the width code.
    for (genvar g = 0; g < 3; g++) begin : gWidth
        dct_link_if lk ();
        assign lk.ten = dTen;
        assign lk.csN = dCsN;
        assign lk.resetN = dResetN;
        assign lk.pat = dPat;
        assign dOut[g] = {lk.dqsPin, lk.dqPin};
        assign dOeN[g] = lk.outOeN;
        dct_device_end #(.WIDTH(dct_pkg::dct_width_e'(g))) dct_device_end_inst (.clk(clk), .sys_rst(sys_rst),
            .link(lk.device), .refreshReq(refreshReq), .refreshGrant(), .testModeActive(), .vrefHalfForced(),
            .normalBypass(), .arrayUndefined(dUndef[g]), .resetFault(dFault[g]));
    end

    // ======================================================================
    // Reference model of the test outputs.
    function automatic logic [19:0] model(input dct_pkg::dct_pattern_s p, input logic gate, input int w);
        logic [9:0] m;
        m[0] = p.addr[1] ^ p.addr[6] ^ p.par;
        m[1] = p.addr[8] ^ p.alertN ^ p.addr[9];
        m[2] = p.addr[2] ^ p.addr[5] ^ p.addr[13];
        m[3] = p.addr[0] ^ p.addr[7] ^ p.addr[11];
        m[4] = p.ckC ^ p.odt ^ p.addr[15];
        m[5] = p.cke ^ p.addr[16] ^ p.addr[10];
        m[6] = p.actN ^ p.addr[4] ^ p.ba[1];
        m[7] = (w == 2 ? p.dmU : p.bg[1]) ^ (w == 0 ? 1'b0 : p.dmL) ^ p.ckT;
        m[8] = p.addr[14] ^ p.addr[12] ^ p.ba[0];
        m[9] = p.bg[0] ^ p.addr[3] ^ gate;
        if (w == 2) begin
            return {~m[9:8], m[9:8], ~m[7:0], m[7:0]};
        end
        if (w == 1) begin
            return {2'h0, m[9:8], 8'h00, m[7:0]};
        end
        return {2'h0, m[9:8], 12'h000, m[6] ^ m[7], m[4] ^ m[5], m[2] ^ m[3], m[0] ^ m[1]};
    endfunction : model

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic all_z();
        check(20'(dOeN), 20'h00007);
        for (int w = 0; w < 3; w++) check(dOut[w], 20'h00000);
    endtask : all_z

    task automatic wait_pulse(input bit useRefused);
        for (int i = 0; i < 40 && (useRefused ? refused : done) !== 1'b1; i++) cyc(1);
        check(20'(useRefused ? refused : done), 20'h00001);
    endtask : wait_pulse

    task automatic stop_test();
        $display("checks=%0d errors=%0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // ======================================================================
    // Clock, timeout and main sequence.
    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errTotal++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(54));
        cyc(4);
        sys_rst = 1'b0;
        dTen = 1'b1;
        dCsN = 1'b0;
        cyc(16);
        all_z();
        dTen = 1'b0;
        dResetN = 1'b1;
        cyc(4);
        dTen = 1'b1;
        dCsN = 1'b1;
        cyc(12);
        all_z();
        dCsN = 1'b0;
        cyc(4);
        repeat (24) begin
            dPat = 30'($urandom);
            cyc(dct_pkg::OUTPUT_VALID_CYC);
            for (int w = 0; w < 3; w++) check(dOut[w] & MASKS[w], model(dPat, 1'b1, w));
        end
        dCsN = 1'b1;
        cyc(1);
        all_z();
        dCsN = 1'b0;
        dResetN = 1'b0;
        cyc(4);
        check(20'(dFault), 20'h00007);
        dResetN = 1'b1;
        cyc(4);
        dTen = 1'b0;
        cyc(1);
        all_z();
        cyc(4);
        check(20'(dUndef), 20'h00007);
        dResetN = 1'b0;
        cyc(4);
        check(20'(dUndef), 20'h00000);
        powerGood = 1'b1;
        refreshReq = 1'b1;
        cyc(3);
        check(20'(refreshGrant), 20'h00001);
        for (int k = 0; k < 2; k++) begin
            pattern = 30'($urandom);
            startReq = 1'b1;
            cyc(1);
            startReq = 1'b0;
            wait_pulse(1'b0);
            check({resultDqs, resultDq}, model(pattern, 1'b1, 2));
            check(20'({busy, resetFault, mismatch, testModeActive, vrefHalfForced, normalBypass, refreshGrant}),
                20'h0000E);
        end
        exitReq = 1'b1;
        cyc(1);
        exitReq = 1'b0;
        cyc(24);
        check(20'({arrayUndefined, resetFault, testModeActive, refreshGrant}), 20'h00001);
        calibrated = 1'b1;
        startReq = 1'b1;
        cyc(1);
        startReq = 1'b0;
        wait_pulse(1'b1);
        stop_test();
    end
endmodule : tb
